// [rtl/dmx_pkg.sv]
package dmx_pkg;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_LOAD_T_SUB_PRODUCT,
    OP_MULTIPLY_ACCUMULATE,
    OP_MULTIPLY_ACCUMULATE_MOVE,
    OP_MULTIPLY_TO_PRODUCT,
    OP_MULTIPLY_LONG_IMMEDIATE,
    OP_MULTIPLY_ADD_PREVIOUS,
    OP_MULTIPLY_SHORT_IMMEDIATE,
    OP_MULTIPLY_SUB_PREVIOUS,
    OP_MULTIPLY_UNSIGNED,
    OP_TWOS_COMPLEMENT_ACC,
    OP_SOFT_NMI,
    OP_LEADING_BIT_ALIGN,
    OP_OR_MEMORY,
    OP_OR_IMMEDIATE,
    OP_PORT_WRITE,
    OP_PRODUCT_TO_ACC_LOAD,
    OP_STACK_PULL_TO_ACC,
    OP_STACK_PULL_TO_MEMORY,
    OP_MEMORY_TO_STACK_SAVE,
    OP_ACC_TO_STACK_SAVE,
    OP_CARRY_CLEAR,
    OP_SUBROUTINE_EXIT,
    OP_CONDITIONAL_SUB_EXIT
  } dmx_op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_IO_SETUP,
    ST_IO_WAIT,
    ST_IO_END
  } dmx_state_t;

  // product shift mode codes
  localparam logic [1:0] PM_NONE = 2'h0;
  localparam logic [1:0] PM_LEFT1 = 2'h1;
  localparam logic [1:0] PM_LEFT4 = 2'h2;
  localparam logic [1:0] PM_RIGHT6 = 2'h3;

  localparam logic [15:0] NMI_VECTOR = 16'h0024;

  // on-chip RAM ranges that take the data move
  localparam logic [15:0] RAM_B2_LO = 16'h0060;
  localparam logic [15:0] RAM_B2_HI = 16'h007F;
  localparam logic [15:0] RAM_B01_LO = 16'h0200;
  localparam logic [15:0] RAM_B01_HI = 16'h03FF;

  // return condition mask bit positions
  localparam int unsigned COND_EQ = 0;
  localparam int unsigned COND_NEQ = 1;
  localparam int unsigned COND_LT = 2;
  localparam int unsigned COND_GT = 3;
  localparam int unsigned COND_C = 4;
  localparam int unsigned COND_NC = 5;
  localparam int unsigned COND_W = 6;

  localparam int unsigned STACK_DEPTH_DEF = 8;
  localparam logic [31:0] ACC_RST = 32'h0000_0000;
  localparam logic [15:0] WORD_RST = 16'h0000;

endpackage

// [rtl/dmx_pshift.sv]
module dmx_pshift (
  input wire logic [1:0] pm_i,     // product shift mode
  input wire logic [31:0] prod_i,  // product register
  output logic [31:0] shifted_o    // shifted product
);

  always_comb begin
    unique case (pm_i)
      dmx_pkg::PM_NONE: shifted_o = prod_i;
      dmx_pkg::PM_LEFT1: shifted_o = {prod_i[30:0], 1'b0};
      dmx_pkg::PM_LEFT4: shifted_o = {prod_i[27:0], 4'h0};
      dmx_pkg::PM_RIGHT6: shifted_o = {{6{prod_i[31]}}, prod_i[31:6]};
    endcase
  end

endmodule

// [rtl/dmx_leading_bit_align.sv]
module dmx_leading_bit_align (
  input wire logic [31:0] acc_i,  // accumulator in
  output logic [31:0] acc_o,      // accumulator after one step
  output logic tc_o               // high when already aligned or zero
);

  // one step per instruction; a loop of the instruction aligns fully
  always_comb begin
    if (acc_i != 32'h0000_0000 && acc_i[31] == acc_i[30]) begin
      acc_o = {acc_i[30:0], 1'b0};
      tc_o = 1'b0;
    end else begin
      acc_o = acc_i;
      tc_o = 1'b1;
    end
  end

endmodule

// [rtl/dmx_exec.sv]
module dmx_exec #(
  parameter int unsigned STACK_DEPTH = dmx_pkg::STACK_DEPTH_DEF
) (
  input wire logic CLK_SYS_I,                        // system clock
  input wire logic RST_N_I,                          // async reset, active low
  input wire logic OP_VALID_I,                       // instruction request
  input wire logic [4:0] OP_CODE_I,                  // instruction code
  input wire logic [15:0] DATA_I,                    // data-memory operand
  input wire logic [15:0] PROG_I,                    // program-memory operand
  input wire logic [15:0] IMM_I,                     // immediate operand
  input wire logic [3:0] SHIFT_I,                    // immediate left shift
  input wire logic [15:0] DADDR_I,                   // operand data address
  input wire logic [15:0] PORT_I,                    // I/O port address
  input wire logic [5:0] COND_MASK_I,                // return conditions
  input wire logic [1:0] PM_I,                       // product shift mode
  input wire logic READY_I,                          // peripheral ready
  output logic BUSY_O,                               // instruction in progress
  output logic DONE_O,                               // instruction finished
  output logic [31:0] ACC_O,                         // accumulator
  output logic [31:0] PREG_O,                        // product register
  output logic [15:0] TREG_O,                        // T register
  output logic CARRY_O,                              // carry bit
  output logic TC_O,                                 // test/control bit
  output logic [15:0] STACK_TOP_O,                   // top stack entry
  output logic PC_LOAD_O,                            // program counter load
  output logic [15:0] PC_O,                          // new program counter
  output logic DMEM_WE_O,                            // data-memory write
  output logic [15:0] DMEM_ADDR_O,                   // data-memory address
  output logic [15:0] DMEM_WDATA_O,                  // data-memory write data
  output logic [15:0] BUS_ADDR_O,                    // external address
  output logic [15:0] BUS_DATA_O,                    // external data out
  output logic BUS_DATA_OE_O,                        // external data enable
  output logic IO_SPACE_STROBE_N_O,                  // I/O space select
  output logic EXTERNAL_ACCESS_STROBE_N_O,           // access strobe
  output logic RW_O                                  // high read, low write
);

  typedef struct packed {
    dmx_pkg::dmx_state_t st;
    logic [31:0] acc;
    logic [31:0] preg;
    logic [15:0] treg;
    logic carry;
    logic tc;
    logic [STACK_DEPTH-1:0][15:0] stk;
    logic busy;
    logic done;
    logic pc_load;
    logic [15:0] pc;
    logic dm_we;
    logic [15:0] dm_addr;
    logic [15:0] dm_wdata;
    logic [15:0] bus_addr;
    logic [15:0] bus_data;
    logic data_oe;
    logic is_n;
    logic external_access_strobe_n;
    logic rw;
  } dmx_exec_state_t;

  dmx_exec_state_t s;
  dmx_exec_state_t nx;
  dmx_pkg::dmx_op_t op;
  logic take;
  logic [31:0] pshift;
  logic [31:0] leading_bit_align_acc;
  logic leading_bit_align_tc;
  logic [32:0] add_res;
  logic [32:0] sub_res;
  logic signed [31:0] prod_mem;
  logic signed [31:0] prod_k13;
  logic signed [31:0] prod_k16;
  logic [31:0] prod_uns;
  logic [31:0] imm_shifted;
  logic [5:0] cond_met;
  logic in_ram;

  assign op = dmx_pkg::dmx_op_t'(OP_CODE_I);
  assign take = OP_VALID_I && s.st == dmx_pkg::ST_IDLE;

  dmx_pshift u_pshift (
    .pm_i(PM_I),
    .prod_i(s.preg),
    .shifted_o(pshift)
  );

  dmx_leading_bit_align u_leading_bit_align (
    .acc_i(s.acc),
    .acc_o(leading_bit_align_acc),
    .tc_o(leading_bit_align_tc)
  );

  assign add_res = {1'b0, s.acc} + {1'b0, pshift};
  assign sub_res = {1'b0, s.acc} - {1'b0, pshift};
  assign prod_mem = $signed(s.treg) * $signed(DATA_I);
  assign prod_k13 = $signed(s.treg) * $signed({{3{IMM_I[12]}}, IMM_I[12:0]});
  assign prod_k16 = $signed(s.treg) * $signed(IMM_I);
  assign prod_uns = {16'h0000, s.treg} * {16'h0000, DATA_I};
  assign imm_shifted = {16'h0000, IMM_I} << SHIFT_I;
  assign in_ram = (DADDR_I >= dmx_pkg::RAM_B2_LO && DADDR_I <= dmx_pkg::RAM_B2_HI)
                  || (DADDR_I >= dmx_pkg::RAM_B01_LO && DADDR_I <= dmx_pkg::RAM_B01_HI);

  always_comb begin
    cond_met = 6'h00;
    cond_met[dmx_pkg::COND_EQ] = s.acc == 32'h0000_0000;
    cond_met[dmx_pkg::COND_NEQ] = s.acc != 32'h0000_0000;
    cond_met[dmx_pkg::COND_LT] = s.acc[31];
    cond_met[dmx_pkg::COND_GT] = !s.acc[31] && s.acc != 32'h0000_0000;
    cond_met[dmx_pkg::COND_C] = s.carry;
    cond_met[dmx_pkg::COND_NC] = !s.carry;
  end

  always_comb begin
    nx = s;
    nx.done = 1'b0;
    nx.pc_load = 1'b0;
    nx.dm_we = 1'b0;
    unique case (s.st)
      dmx_pkg::ST_IDLE: begin
        if (take) begin
          nx.done = 1'b1;
          unique case (op)
            dmx_pkg::OP_LOAD_T_SUB_PRODUCT: begin
              nx.treg = DATA_I;
              nx.acc = sub_res[31:0];
              nx.carry = ~sub_res[32];
            end
            dmx_pkg::OP_MULTIPLY_ACCUMULATE, dmx_pkg::OP_MULTIPLY_ACCUMULATE_MOVE: begin
              nx.treg = DATA_I;
              nx.preg = 32'($signed(DATA_I) * $signed(PROG_I));
              nx.acc = add_res[31:0];
              nx.carry = add_res[32];
              if (op == dmx_pkg::OP_MULTIPLY_ACCUMULATE_MOVE && in_ram) begin
                nx.dm_we = 1'b1;
                nx.dm_addr = DADDR_I + 16'h0001;
                nx.dm_wdata = DATA_I;
              end
            end
            dmx_pkg::OP_MULTIPLY_TO_PRODUCT: nx.preg = prod_mem;
            dmx_pkg::OP_MULTIPLY_LONG_IMMEDIATE: nx.preg = prod_k16;
            dmx_pkg::OP_MULTIPLY_SHORT_IMMEDIATE: nx.preg = prod_k13;
            dmx_pkg::OP_MULTIPLY_ADD_PREVIOUS: begin
              nx.preg = prod_mem;
              nx.acc = add_res[31:0];
              nx.carry = add_res[32];
            end
            dmx_pkg::OP_MULTIPLY_SUB_PREVIOUS: begin
              nx.preg = prod_mem;
              nx.acc = sub_res[31:0];
              nx.carry = ~sub_res[32];
            end
            dmx_pkg::OP_MULTIPLY_UNSIGNED: nx.preg = prod_uns;
            dmx_pkg::OP_TWOS_COMPLEMENT_ACC: nx.acc = 32'h0000_0000 - s.acc;
            dmx_pkg::OP_SOFT_NMI: begin
              nx.pc_load = 1'b1;
              nx.pc = dmx_pkg::NMI_VECTOR;
            end
            dmx_pkg::OP_LEADING_BIT_ALIGN: begin
              nx.acc = leading_bit_align_acc;
              nx.tc = leading_bit_align_tc;
            end
            dmx_pkg::OP_OR_MEMORY: nx.acc = s.acc | {16'h0000, DATA_I};
            dmx_pkg::OP_OR_IMMEDIATE: nx.acc = s.acc | imm_shifted;
            dmx_pkg::OP_PORT_WRITE: begin
              nx.done = 1'b0;
              nx.busy = 1'b1;
              nx.bus_addr = PORT_I;
              nx.bus_data = DATA_I;
              nx.data_oe = 1'b1;
              nx.is_n = 1'b0;
              nx.rw = 1'b0;
              nx.st = dmx_pkg::ST_IO_SETUP;
            end
            dmx_pkg::OP_PRODUCT_TO_ACC_LOAD: nx.acc = pshift;
            dmx_pkg::OP_STACK_PULL_TO_ACC: begin
              nx.acc = {16'h0000, s.stk[0]};
              nx.stk = {s.stk[STACK_DEPTH-1], s.stk[STACK_DEPTH-1:1]};
            end
            dmx_pkg::OP_STACK_PULL_TO_MEMORY: begin
              nx.dm_we = 1'b1;
              nx.dm_addr = DADDR_I;
              nx.dm_wdata = s.stk[0];
              nx.stk = {s.stk[STACK_DEPTH-1], s.stk[STACK_DEPTH-1:1]};
            end
            dmx_pkg::OP_MEMORY_TO_STACK_SAVE: nx.stk = {s.stk[STACK_DEPTH-2:0], DATA_I};
            dmx_pkg::OP_ACC_TO_STACK_SAVE: nx.stk = {s.stk[STACK_DEPTH-2:0], s.acc[15:0]};
            dmx_pkg::OP_CARRY_CLEAR: nx.carry = 1'b0;
            dmx_pkg::OP_SUBROUTINE_EXIT, dmx_pkg::OP_CONDITIONAL_SUB_EXIT: begin
              if (op == dmx_pkg::OP_SUBROUTINE_EXIT || &(~COND_MASK_I | cond_met)) begin
                nx.pc_load = 1'b1;
                nx.pc = s.stk[0];
                nx.stk = {s.stk[STACK_DEPTH-1], s.stk[STACK_DEPTH-1:1]};
              end
            end
            default: ;
          endcase
        end
      end
      dmx_pkg::ST_IO_SETUP: begin
        nx.external_access_strobe_n = 1'b0;
        nx.st = dmx_pkg::ST_IO_WAIT;
      end
      dmx_pkg::ST_IO_WAIT: begin
        if (READY_I) begin
          nx.external_access_strobe_n = 1'b1;
          nx.st = dmx_pkg::ST_IO_END;
        end
      end
      dmx_pkg::ST_IO_END: begin
        nx.is_n = 1'b1;
        nx.rw = 1'b1;
        nx.data_oe = 1'b0;
        nx.busy = 1'b0;
        nx.done = 1'b1;
        nx.st = dmx_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s <= '0;
      s.st <= dmx_pkg::ST_IDLE;
      s.acc <= dmx_pkg::ACC_RST;
      s.is_n <= 1'b1;
      s.external_access_strobe_n <= 1'b1;
      s.rw <= 1'b1;
    end else begin
      s <= nx;
    end
  end

  assign BUSY_O = s.busy;
  assign DONE_O = s.done;
  assign ACC_O = s.acc;
  assign PREG_O = s.preg;
  assign TREG_O = s.treg;
  assign CARRY_O = s.carry;
  assign TC_O = s.tc;
  assign STACK_TOP_O = s.stk[0];
  assign PC_LOAD_O = s.pc_load;
  assign PC_O = s.pc;
  assign DMEM_WE_O = s.dm_we;
  assign DMEM_ADDR_O = s.dm_addr;
  assign DMEM_WDATA_O = s.dm_wdata;
  assign BUS_ADDR_O = s.bus_addr;
  assign BUS_DATA_O = s.bus_data;
  assign BUS_DATA_OE_O = s.data_oe;
  assign IO_SPACE_STROBE_N_O = s.is_n;
  assign EXTERNAL_ACCESS_STROBE_N_O = s.external_access_strobe_n;
  assign RW_O = s.rw;

  chk_nmi_vector: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    take && op == dmx_pkg::OP_SOFT_NMI |=> PC_LOAD_O && PC_O == 16'h0024)
    else $error("trap did not jump to vector");

  chk_return_pop: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    take && op == dmx_pkg::OP_SUBROUTINE_EXIT |=> PC_LOAD_O && PC_O == $past(s.stk[0])
      && s.stk[0] == $past(s.stk[1]))
    else $error("return did not load PC and pop");

  chk_negate_acc: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    take && op == dmx_pkg::OP_TWOS_COMPLEMENT_ACC |=> ACC_O + $past(ACC_O) == 32'h0000_0000)
    else $error("negate result wrong");

  chk_carry_clear: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    take && op == dmx_pkg::OP_CARRY_CLEAR |=> !CARRY_O && $stable(ACC_O) && $stable(PREG_O)
      && $stable(TC_O))
    else $error("carry clear disturbed state");

  chk_io_strobe_pair: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    !EXTERNAL_ACCESS_STROBE_N_O |-> !IO_SPACE_STROBE_N_O && !RW_O && BUS_DATA_OE_O)
    else $error("strobe without I/O write setup");

  chk_ready_extend: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    s.st == dmx_pkg::ST_IO_WAIT && !READY_I |=> !EXTERNAL_ACCESS_STROBE_N_O)
    else $error("strobe ended before ready");

  chk_push_low_acc: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    take && op == dmx_pkg::OP_ACC_TO_STACK_SAVE |=> STACK_TOP_O == $past(ACC_O[15:0])
      && s.stk[1] == $past(s.stk[0]))
    else $error("push of low accumulator wrong");

  chk_short_imm_mul: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    take && op == dmx_pkg::OP_MULTIPLY_SHORT_IMMEDIATE |=> $signed(PREG_O) == $signed($past(TREG_O))
      * $signed({{3{$past(IMM_I[12])}}, $past(IMM_I[12:0])}))
    else $error("short immediate product wrong");

  chk_pull_to_acc: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    take && op == dmx_pkg::OP_STACK_PULL_TO_ACC |=> ACC_O == {16'h0000, $past(STACK_TOP_O)})
    else $error("pull to accumulator wrong");

  chk_move_in_ram: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    take && op == dmx_pkg::OP_MULTIPLY_ACCUMULATE_MOVE |=> DMEM_WE_O == $past(in_ram))
    else $error("data move gating wrong");

endmodule

// [verif/dmx_io_model.sv]
module dmx_io_model (
  input wire logic clk_i,          // system clock
  input wire logic rst_n_i,        // reset, active low
  input wire logic strobe_n_i,     // access strobe
  input wire logic io_n_i,         // i/o space select
  input wire logic rw_i,           // high read
  input wire logic oe_i,           // data enable
  input wire logic [15:0] addr_i,  // port address
  input wire logic [15:0] data_i,  // write data
  input wire logic [3:0] wait_i,   // extra wait cycles
  input wire logic clr_i,          // clear record
  output logic ready_o,            // peripheral ready
  output logic [15:0] got_addr_o,  // latched address
  output logic [15:0] got_data_o,  // latched data
  output logic [7:0] low_o,        // strobe low cycles
  output logic bad_o               // qualifier wrong while strobed
);
  timeunit 1ns;
  timeprecision 1ps;
  // ready only while strobed, never left high between accesses
  assign ready_o = !strobe_n_i && (low_o >= {4'h0, wait_i});
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_o <= 8'h00;
      bad_o <= 1'b0;
      got_addr_o <= 16'h0000;
      got_data_o <= 16'h0000;
    end else if (clr_i) begin
      low_o <= 8'h00;
      bad_o <= 1'b0;
    end else if (!strobe_n_i) begin
      low_o <= low_o + 8'h01;
      got_addr_o <= addr_i;
      got_data_o <= data_i;
      bad_o <= bad_o | io_n_i | rw_i | !oe_i;
    end
  end
endmodule

// [verif/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, clr = 1'b0, ready;
  logic [4:0] code = 5'h00;
  logic [15:0] data = 16'h0000, prog = 16'h0000, imm = 16'h0000, daddr = 16'h0000, port = 16'h0000;
  logic [3:0] shift = 4'h0, wt = 4'h0;
  logic [5:0] cond = 6'h00;
  logic [1:0] pm = 2'h0;
  logic busy, done, carry, tc, pcl, we, oe, is_n, st_n, rw, bad;
  logic [31:0] acc, preg;
  logic [15:0] treg, top, pc, maddr, mdata, baddr, bdata, gaddr, gdata;
  logic [7:0] low;
  int n_errors = 0;
  int n_checks = 0;
  int ncyc;
  logic saw_busy;
  always #2 clk = ~clk;

  dmx_exec dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .OP_VALID_I(valid), .OP_CODE_I(code), .DATA_I(data),
    .PROG_I(prog), .IMM_I(imm), .SHIFT_I(shift), .DADDR_I(daddr), .PORT_I(port), .COND_MASK_I(cond),
    .PM_I(pm), .READY_I(ready), .BUSY_O(busy), .DONE_O(done), .ACC_O(acc), .PREG_O(preg), .TREG_O(treg),
    .CARRY_O(carry), .TC_O(tc), .STACK_TOP_O(top), .PC_LOAD_O(pcl), .PC_O(pc), .DMEM_WE_O(we),
    .DMEM_ADDR_O(maddr), .DMEM_WDATA_O(mdata), .BUS_ADDR_O(baddr), .BUS_DATA_O(bdata),
    .BUS_DATA_OE_O(oe), .IO_SPACE_STROBE_N_O(is_n), .EXTERNAL_ACCESS_STROBE_N_O(st_n), .RW_O(rw));

  dmx_io_model io (.clk_i(clk), .rst_n_i(rst_n), .strobe_n_i(st_n), .io_n_i(is_n), .rw_i(rw), .oe_i(oe),
    .addr_i(baddr), .data_i(bdata), .wait_i(wt), .clr_i(clr), .ready_o(ready), .got_addr_o(gaddr),
    .got_data_o(gdata), .low_o(low), .bad_o(bad));

  task automatic conclude();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one request, then wait for the completion pulse under a bound
  task automatic go(input dmx_pkg::dmx_op_t op);
    @(negedge clk);
    code = op;
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    ncyc = 1;
    saw_busy = busy;
    while (done !== 1'b1 && ncyc < 40) begin
      @(negedge clk);
      ncyc++;
      saw_busy = saw_busy | busy;
    end
    if (done !== 1'b1) begin
      n_errors++;
      $display("[FAIL] done expected 1 seen %b", done);
      conclude();
    end
  endtask

  task automatic t_reset();
    chk("reset state", 32'h0, acc | preg);
    chk("reset bus", 32'h7, {is_n, st_n, rw});
  endtask

  task automatic t_product();
    logic [31:0] e[4];
    e = '{32'hFFFFFFFA, 32'hFFFFFFF4, 32'hFFFFFFA0, 32'hFFFFFFFF};
    data = 16'h0003;
    go(dmx_pkg::OP_LOAD_T_SUB_PRODUCT);
    chk("treg", 32'h3, treg);
    data = 16'hFFFE;
    go(dmx_pkg::OP_MULTIPLY_TO_PRODUCT);
    chk("preg", 32'hFFFFFFFA, preg);
    for (int i = 3; i >= 0; i--) begin
      pm = i[1:0];
      go(dmx_pkg::OP_PRODUCT_TO_ACC_LOAD);
      chk("pac", e[i], acc);
    end
    data = 16'h0005;
    go(dmx_pkg::OP_LOAD_T_SUB_PRODUCT);
    chk("lts acc", 32'h0, acc);
    chk("lts treg", 32'h5, treg);
    chk("lts carry", 32'h1, carry);
    go(dmx_pkg::OP_CARRY_CLEAR);
    chk("carry", 32'h0, carry);
    chk("acc kept", 32'h0, acc);
    chk("preg kept", 32'hFFFFFFFA, preg);
  endtask

  task automatic t_prev();
    imm = 16'h3001;
    go(dmx_pkg::OP_MULTIPLY_SHORT_IMMEDIATE);
    chk("multiply_short_immediate", 32'hFFFFB005, preg);
    data = 16'h0002;
    pm = 2'h1;
    go(dmx_pkg::OP_MULTIPLY_ADD_PREVIOUS);
    chk("multiply_add_previous acc", 32'hFFFF600A, acc);
    chk("multiply_add_previous preg", 32'hA, preg);
    data = 16'h0003;
    pm = 2'h0;
    go(dmx_pkg::OP_MULTIPLY_SUB_PREVIOUS);
    chk("multiply_sub_previous acc", 32'hFFFF6000, acc);
    chk("multiply_sub_previous preg", 32'hF, preg);
    data = 16'hFFFF;
    go(dmx_pkg::OP_MULTIPLY_UNSIGNED);
    chk("multiply_unsigned", 32'h0004FFFB, preg);
  endtask

  task automatic t_acc();
    go(dmx_pkg::OP_TWOS_COMPLEMENT_ACC);
    chk("neg", 32'h0000A000, acc);
    chk("neg cycles", 32'h1, ncyc);
    go(dmx_pkg::OP_LEADING_BIT_ALIGN);
    chk("leading_bit_align", 32'h00014000, acc);
    chk("leading_bit_align tc", 32'h0, tc);
    go(dmx_pkg::OP_SOFT_NMI);
    chk("nmi", 32'h10024, {pcl, pc});
  endtask

  task automatic t_mac();
    logic [15:0] a[8];
    logic [7:0] w;
    a = '{16'h005F, 16'h0060, 16'h007F, 16'h0080, 16'h01FF, 16'h0200, 16'h03FF, 16'h0400};
    w = 8'h66;
    imm = 16'h0100;
    go(dmx_pkg::OP_MULTIPLY_LONG_IMMEDIATE);
    chk("mpy long", 32'h500, preg);
    data = 16'h0004;
    prog = 16'h0007;
    go(dmx_pkg::OP_MULTIPLY_ACCUMULATE);
    chk("mac acc", 32'h00014500, acc);
    chk("mac preg", 32'h1C, preg);
    data = 16'h00AA;
    prog = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      daddr = a[i];
      go(dmx_pkg::OP_MULTIPLY_ACCUMULATE_MOVE);
      chk("move we", w[i], we);
      if (w[i]) chk("move", {a[i] + 16'h0001, 16'h00AA}, {maddr, mdata});
    end
    chk("multiply_accumulate_move acc", 32'h0001451C, acc);
  endtask

  task automatic t_or();
    imm = 16'h00F1;
    shift = 4'h4;
    go(dmx_pkg::OP_OR_IMMEDIATE);
    chk("or imm", 32'h00014F1C, acc);
    data = 16'h8001;
    go(dmx_pkg::OP_OR_MEMORY);
    chk("or mem", 32'h0001CF1D, acc);
    imm = 16'h0005;
    shift = 4'hF;
    go(dmx_pkg::OP_OR_IMMEDIATE);
    chk("or top shift", 32'h0003CF1D, acc);
  endtask

  task automatic t_stack();
    data = 16'h1234;
    go(dmx_pkg::OP_MEMORY_TO_STACK_SAVE);
    chk("memory_to_stack_save", 32'h1234, top);
    go(dmx_pkg::OP_ACC_TO_STACK_SAVE);
    chk("push", 32'hCF1D, top);
    go(dmx_pkg::OP_STACK_PULL_TO_ACC);
    chk("pop acc", 32'h0000CF1D, acc);
    chk("pop top", 32'h1234, top);
    daddr = 16'h0300;
    go(dmx_pkg::OP_STACK_PULL_TO_MEMORY);
    chk("stack_pull_to_memory", 32'h03001234, {maddr, mdata});
    chk("stack_pull_to_memory we", 32'h1, we);
    data = 16'hBEEF;
    go(dmx_pkg::OP_MEMORY_TO_STACK_SAVE);
    go(dmx_pkg::OP_SUBROUTINE_EXIT);
    chk("ret", 32'h1BEEF, {pcl, pc});
    data = 16'h0ABC;
    go(dmx_pkg::OP_MEMORY_TO_STACK_SAVE);
    cond = 6'h06;
    go(dmx_pkg::OP_CONDITIONAL_SUB_EXIT);
    chk("conditional_sub_exit skip", 32'h00ABC, {pcl, top});
    cond = 6'h0A;
    go(dmx_pkg::OP_CONDITIONAL_SUB_EXIT);
    chk("conditional_sub_exit take", 32'h10ABC, {pcl, pc});
  endtask

  task automatic t_port();
    for (int w = 0; w < 4; w += 3) begin
      wt = w[3:0];
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      data = 16'h5A5A;
      port = 16'h00F0 + w[15:0];
      go(dmx_pkg::OP_PORT_WRITE);
      chk("io cycles", w + 4, ncyc);
      chk("busy seen", 32'h1, saw_busy);
      chk("strobe low", w + 1, low);
      chk("io word", {port, 16'h5A5A}, {gaddr, gdata});
      chk("io qualifiers", 32'h0, bad);
      chk("io idle", 32'h7, {busy, oe, is_n, st_n, rw});
    end
  endtask

  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_product();
    t_prev();
    t_acc();
    t_mac();
    t_or();
    t_stack();
    t_port();
    conclude();
  end
endmodule
